// ---- rtl/gcb_ctrl.sv ----
// General control bits: buffer power, config lock and DAC broadcast.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Register map, one aligned word each:
//   control at GCB_CTRL_ADDR: precharge, buffer enable, lock and broadcast
//   bits at their package positions; the reserved bit and all others read 0.
//   status at GCB_STAT_ADDR, read only: buffer power and conversion activity.
// An access to any other offset changes nothing and ends with pslverr.
//
// Bus timing: pready rises in the second access cycle. The write takes
// effect, and read data and pslverr are valid, at the edge that samples it.
// Back-to-back transfers are accepted.
//
// Buffer outputs follow the control bits and conv_active in the same cycle.
// The pin configuration gate is combinational as well.
//
// A DAC write request is taken at the edge where dac_wr_in.valid is high.
// One cycle later dac_load shows the strobes for one cycle and dac_data the
// data word, which then holds until the next request.
//
// Reset is synchronous and active low: all control bits return to zero, the
// buffer is powered down, no strobe is raised and the bus reads zero.
//
// The block runs on one clock and takes every input as synchronous to it.
// Outputs that carry data come from flip-flops; handshake ones need not.
//
// Limitation: the block has no notion of which channels are DACs; that
// mapping lives with the strobe consumer.
////////////////////////////////////////////////////////////////////////////////
module gcb_ctrl
   import gcb_pkg::*;
#(
   parameter int NCH = GCB_NCH_DEF
) (
   // Clock and reset.
   input  wire logic              clock,
   input  wire logic              rstn,

   // Register bus.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [GCB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,

   // Buffer power.
   input  wire logic              conv_active,
   output logic                   buf_power,
   output logic                   buf_precharge,

   // Pin configuration gate.
   input  wire logic              pincfg_wr_req,
   output logic                   pincfg_wr_en,

   // DAC write routing.
   input  wire gcb_dac_wr_t       dac_wr_in,
   output logic [NCH-1:0]         dac_load,
   output logic [11:0]            dac_data
);

   ////////////////////////////////////////////////////////////////////////////
   // Register interface.
   // Every access takes one wait state. The first access cycle loads the read
   // data and the error flag into flip-flops; the second raises pready, so
   // the master finds both settled at the edge at which it samples them.
   // Writes land only at that edge, which keeps a transfer that the master
   // abandons early from touching the control bits.
   gcb_ctrl_t   ctrl_reg,   ctrl_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        err_reg,    err_next;
   logic        wait_reg,   wait_next;
   logic        access;
   logic        first_acc;
   logic        done_acc;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        wr_ctrl;
   logic        rd_any;

   assign access    = psel & penable;
   assign first_acc = access & ~wait_reg;
   assign done_acc  = access & wait_reg;
   assign hit_ctrl  = (paddr == GCB_CTRL_ADDR);
   assign hit_stat  = (paddr == GCB_STAT_ADDR);
   assign wr_ctrl   = done_acc & pwrite & hit_ctrl;
   assign rd_any    = first_acc & ~pwrite;

   // The handshake outputs are combinational; the data behind them is not.
   assign pready  = done_acc;
   assign pslverr = done_acc & err_reg;
   assign prdata  = prdata_reg;

   always_comb begin
      ctrl_next   = ctrl_reg;
      prdata_next = prdata_reg;
      err_next    = 1'b0;
      wait_next   = first_acc;
      if (wr_ctrl) begin
         // The reserved bit is dropped; software must keep it at zero.
         ctrl_next.precharge           = pwdata[GCB_BIT_PRECHG];
         ctrl_next.buf_enable          = pwdata[GCB_BIT_BUFEN];
         ctrl_next.cfg_lock            = pwdata[GCB_BIT_LOCK];
         ctrl_next.broadcast_dac_write = pwdata[GCB_BIT_BCAST];
      end
      if (rd_any) begin
         // Unused bits, the reserved one included, read as zero.
         prdata_next = GCB_ZERO;
         if (hit_ctrl) begin
            prdata_next[GCB_BIT_PRECHG] = ctrl_reg.precharge;
            prdata_next[GCB_BIT_BUFEN]  = ctrl_reg.buf_enable;
            prdata_next[GCB_BIT_LOCK]   = ctrl_reg.cfg_lock;
            prdata_next[GCB_BIT_BCAST]  = ctrl_reg.broadcast_dac_write;
         end else if (hit_stat) begin
            prdata_next[GCB_BIT_STAT_PWR]  = buf_power;
            prdata_next[GCB_BIT_STAT_CONV] = conv_active;
         end
      end
      // An unmapped offset is flagged in the first access cycle and held
      // through the second, where pslverr presents it.
      if (first_acc) begin
         err_next = ~(hit_ctrl | hit_stat);
      end else if (done_acc) begin
         err_next = err_reg;
      end
   end

   // A transfer cut by reset is lost; the master has to start it again.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_reg   <= gcb_ctrl_t'(
                          GCB_CTRL_RESET[GCB_BIT_PRECHG:GCB_BIT_BCAST]);
         prdata_reg <= GCB_ZERO;
         err_reg    <= 1'b0;
         wait_reg   <= 1'b0;
      end else begin
         ctrl_reg   <= ctrl_next;
         prdata_reg <= prdata_next;
         err_reg    <= err_next;
         wait_reg   <= wait_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer power.
   // Precharge mode trades a little settling for lower idle current by
   // powering the buffer only while a conversion runs. With the buffer
   // disabled both outputs stay low whatever the precharge bit says, so the
   // converter never waits on a buffer that is off.
   always_comb begin
      if (!ctrl_reg.buf_enable) begin
         buf_power = 1'b0;
      end else if (ctrl_reg.precharge) begin
         buf_power = conv_active;
      end else begin
         buf_power = 1'b1;
      end
   end

   assign buf_precharge = ctrl_reg.buf_enable & ctrl_reg.precharge;

   ////////////////////////////////////////////////////////////////////////////
   // Pin configuration write gate.
   // The gate is combinational so that a request sees the lock at once. A
   // lock written at an edge blocks requests from the next cycle on; a
   // request in the very cycle of that write still passes.
   assign pincfg_wr_en = pincfg_wr_req & ~ctrl_reg.cfg_lock;

   ////////////////////////////////////////////////////////////////////////////
   // DAC write routing.
   // Load strobes and data are registered, one cycle after the request.
   // Broadcast raises every strobe; the consumer masks the strobes of the
   // channels that are not configured as DACs.
   logic [NCH-1:0] load_reg, load_next;
   logic [11:0]    data_reg, data_next;

   // One selector per channel; with broadcast off, an out-of-range channel loads nothing.
   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_sel
         always_comb begin
            if (!dac_wr_in.valid) begin
               load_next[ch] = 1'b0;
            end else if (ctrl_reg.broadcast_dac_write) begin
               load_next[ch] = 1'b1;
            end else begin
               load_next[ch] = (int'(dac_wr_in.chan) == ch);
            end
         end
      end
   endgenerate

   // The data word is held between writes so that a slow consumer still
   // sees the value that went with the last strobe.
   assign data_next = dac_wr_in.valid ? dac_wr_in.data : data_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         load_reg <= '0;
         data_reg <= 12'h000;
      end else begin
         load_reg <= load_next;
         data_reg <= data_next;
      end
   end

   assign dac_load = load_reg;
   assign dac_data = data_reg;
endmodule : gcb_ctrl

// ---- rtl/gcb_pkg.sv ----
// Package with register map, field positions and types of the control block.
package gcb_pkg;
   localparam int          GCB_AW          = 8;
   localparam int          GCB_NCH_DEF     = 8;
   localparam logic [7:0]  GCB_CTRL_ADDR   = 8'h00;
   localparam logic [7:0]  GCB_STAT_ADDR   = 8'h04;
   localparam int          GCB_BIT_BCAST   = 6;
   localparam int          GCB_BIT_LOCK    = 7;
   localparam int          GCB_BIT_BUFEN   = 8;
   localparam int          GCB_BIT_PRECHG  = 9;
   localparam int          GCB_BIT_RSVD    = 10;
   localparam int          GCB_BIT_STAT_PWR  = 0;
   localparam int          GCB_BIT_STAT_CONV = 1;
   localparam logic [31:0] GCB_CTRL_RESET  = 32'h0000_0000;
   localparam logic [31:0] GCB_CTRL_MASK   = 32'h0000_03c0;
   localparam logic [31:0] GCB_ZERO        = 32'h0000_0000;

   typedef struct packed {
      logic        precharge;
      logic        buf_enable;
      logic        cfg_lock;
      logic        broadcast_dac_write;
   } gcb_ctrl_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  chan;
      logic [11:0] data;
   } gcb_dac_wr_t;
endpackage : gcb_pkg

// ---- testbench/gcb_conv_model.sv ----
// Converter sequencer stand-in that pulses conversion activity.
`timescale 1ns/1ps
module gcb_conv_model (
   input  wire logic clock,
   input  wire logic rstn,
   output logic      conv_active
);
   logic [2:0] cnt_reg;
   always_ff @(posedge clock) begin
      cnt_reg <= rstn ? cnt_reg + 3'h1 : 3'h0;
   end
   assign conv_active = cnt_reg[2] & cnt_reg[1];
endmodule : gcb_conv_model

// ---- testbench/gcb_ctrl_monitor.sv ----
// Checker on the control block ports.
`timescale 1ns/1ps
module gcb_ctrl_monitor
   import gcb_pkg::*;
#(parameter int NCH = GCB_NCH_DEF) (
   input wire logic           clock,
   input wire logic           rstn,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic           conv_active,
   input wire logic           buf_power,
   input wire logic           pincfg_wr_req,
   input wire logic           pincfg_wr_en,
   input wire gcb_dac_wr_t    dac_wr_in,
   input wire logic [NCH-1:0] dac_load,
   input wire logic [11:0]    dac_data
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   logic wr;
   assign wr = psel & penable & pwrite;
   a_gate_needs_req: assert property (!pincfg_wr_req |-> !pincfg_wr_en)
      else $error("pin config gate open without request");
   a_gate_holds: assert property ($changed(pincfg_wr_en)
      && $stable(pincfg_wr_req) |-> $past(wr)) else $error("gate moved");
   a_buf_rise: assert property ($rose(buf_power)
      |-> conv_active || $past(wr)) else $error("buffer woke early");
   a_buf_fall: assert property ($fell(buf_power)
      |-> !conv_active || $past(wr)) else $error("buffer dropped");
   a_load_data: assert property (dac_wr_in.valid
      |=> dac_data == $past(dac_wr_in.data)) else $error("dac data");
   a_load_idle: assert property (!dac_wr_in.valid |=> dac_load == '0)
      else $error("stray dac load");
   a_load_chan: assert property (dac_wr_in.valid
      |=> dac_load[$past(dac_wr_in.chan)]) else $error("channel missed");
   a_load_shape: assert property (dac_wr_in.valid
      |=> $onehot(dac_load) || &dac_load) else $error("load shape");
   cover property (dac_wr_in.valid ##1 &dac_load);
   cover property ($rose(buf_power) && conv_active);
   cover property (pincfg_wr_req && !pincfg_wr_en);
endmodule : gcb_ctrl_monitor
bind gcb_ctrl gcb_ctrl_monitor #(.NCH(NCH)) u_mon (.clock(clock), .rstn(rstn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .conv_active(conv_active),
   .buf_power(buf_power), .pincfg_wr_req(pincfg_wr_req),
   .pincfg_wr_en(pincfg_wr_en), .dac_wr_in(dac_wr_in), .dac_load(dac_load),
   .dac_data(dac_data));

// ---- testbench/gcb_ctrl_tb.sv ----
// Self-checking bench for the general control block.
`timescale 1ns/1ps
module gcb_ctrl_tb;
   import gcb_pkg::*;
   logic clock, rstn, psel, penable, pwrite, pready, pslverr, conv_active;
   logic buf_power, buf_precharge, pincfg_wr_req, pincfg_wr_en;
   logic [7:0] paddr, dac_load;
   logic [31:0] pwdata, prdata;
   logic [11:0] dac_data;
   gcb_dac_wr_t dac_wr_in;
   logic [31:0] rd;
   logic er;
   int mismatches, tests_run;
   gcb_ctrl #(.NCH(8)) u_dut (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_active(conv_active), .buf_power(buf_power),
      .buf_precharge(buf_precharge), .pincfg_wr_req(pincfg_wr_req),
      .pincfg_wr_en(pincfg_wr_en), .dac_wr_in(dac_wr_in),
      .dac_load(dac_load), .dac_data(dac_data));
   gcb_conv_model u_conv (.clock(clock), .rstn(rstn), .conv_active(conv_active));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clock) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clock) penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      @(negedge clock);
   endtask : apb
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   task automatic t_reset;
      apb(1'b0, GCB_CTRL_ADDR, GCB_ZERO, rd, er);
      chk("ctrl", GCB_CTRL_RESET, rd);
      chk("ctrl_err", 0, er);
      chk("buf", 0, buf_power);
      chk("pre0", 0, buf_precharge);
   endtask : t_reset
   task automatic t_buffer;
      apb(1'b1, GCB_CTRL_ADDR, 32'h0000_0100, rd, er);
      repeat (8) @(negedge clock) chk("on", 1, buf_power);
      apb(1'b0, GCB_STAT_ADDR, GCB_ZERO, rd, er);
      chk("stat_pwr", 1, rd[GCB_BIT_STAT_PWR]);
      apb(1'b1, GCB_CTRL_ADDR, 32'h0000_0300, rd, er);
      chk("pre", 1, buf_precharge);
      repeat (8) @(negedge clock) chk("pc", conv_active, buf_power);
      apb(1'b0, GCB_CTRL_ADDR, GCB_ZERO, rd, er);
      chk("ctrl_rd", 32'h0000_0300, rd);
      apb(1'b1, GCB_CTRL_ADDR, 32'h0000_0200, rd, er);
      chk("off", 0, buf_power);
      chk("pre_off", 0, buf_precharge);
   endtask : t_buffer
   task automatic t_lock;
      @(posedge clock) pincfg_wr_req <= 1'b1;
      @(negedge clock) chk("gate", 1, pincfg_wr_en);
      apb(1'b1, GCB_CTRL_ADDR, 32'h0000_0080, rd, er);
      chk("locked", 0, pincfg_wr_en);
      apb(1'b1, 8'h10, GCB_ZERO, rd, er);
      chk("err", 1, er);
      chk("kept", 0, pincfg_wr_en);
   endtask : t_lock
   task automatic t_dac(input logic b, input logic [11:0] d);
      apb(1'b1, GCB_CTRL_ADDR, {25'h0, b, 6'h0}, rd, er);
      @(posedge clock) dac_wr_in <= '{1'b1, 3'h5, d};
      @(posedge clock) dac_wr_in.valid <= 1'b0;
      @(negedge clock) chk("load", b ? 8'hff : 8'h20, dac_load);
      chk("data", d, dac_data);
      @(negedge clock) chk("idle", 0, dac_load);
   endtask : t_dac
   task automatic t_rerun;
      apb(1'b1, GCB_CTRL_ADDR, 32'h0000_03c0, rd, er);
      @(posedge clock) rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      apb(1'b0, GCB_CTRL_ADDR, GCB_ZERO, rd, er);
      chk("rerun", GCB_CTRL_RESET, rd);
      chk("rerun_buf", 0, buf_power);
   endtask : t_rerun
   initial begin
      {psel, penable, pwrite, pincfg_wr_req, rstn} = '0;
      {paddr, pwdata, dac_wr_in} = '0;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      t_reset();
      t_buffer();
      t_lock();
      t_dac(1'b0, 12'h5a5);
      t_dac(1'b1, 12'h3c3);
      t_rerun();
      tally_and_finish();
   end
   initial begin
      #2000000;
      mismatches++;
      tally_and_finish();
   end
endmodule : gcb_ctrl_tb
